// file: rtl/lcs_charge_seq.sv
// Single-cell lithium charge sequencer with Wishbone register access
`timescale 1ns/1ps
`include "lcs_map.svh"
module lcs_charge_seq #(
   parameter int TOSC_CYC      = `LCS_TOSC_CYC,
   parameter int PLUG_TICKS    = (`LCS_PLUG_MS * 1000000 + `LCS_TOSC_NS - 1) / `LCS_TOSC_NS,
   parameter int SETTLE_TICKS  = (`LCS_SETTLE_MS * 1000000 + `LCS_TOSC_NS - 1) / `LCS_TOSC_NS,
   parameter int VERIFY_TICKS  = (`LCS_VERIFY_MS * 1000000 + `LCS_TOSC_NS - 1) / `LCS_TOSC_NS,
   parameter int TIMEOUT_TICKS = `LCS_TIMEOUT_TICKS
) (
   input  wire logic                 SYS_CLK,
   input  wire logic                 SRST,
   input  wire logic                 CHARGE_EN_N,
   input  wire logic                 BAT_OPEN,
   input  wire logic                 BAT_BELOW_1V,
   input  wire logic                 BAT_BELOW_VMIN,
   input  wire logic                 BAT_AT_TARGET,
   input  wire logic                 BAT_BELOW_RECHG,
   input  wire logic                 CUR_BELOW_MIN,
   input  wire logic                 AMB_BELOW_LOW,
   input  wire logic                 AMB_ABOVE_IDLE_MAX,
   input  wire logic                 AMB_ABOVE_CHG_MAX,
   input  wire logic                 DIE_HOT,
   input  wire logic [7:0]           WB_ADR_I,
   input  wire logic [31:0]          WB_DAT_I,
   input  wire logic [3:0]           WB_SEL_I,
   input  wire logic                 WB_WE_I,
   input  wire logic                 WB_CYC_I,
   input  wire logic                 WB_STB_I,
   output logic [31:0]               WB_DAT_O,
   output logic                      WB_ACK_O,
   output logic                      RED_DRIVE_OE,
   output logic                      GREEN_INDICATOR_DRIVE_OE,
   output logic                      CHARGE_ON,
   output lcs_pkg::lcs_phase_t       CHARGE_PHASE,
   output logic                      FOLDBACK,
   output logic                      IRQ
);
   import lcs_pkg::*;

   localparam int TW = `LCS_TICK_W;

   // Counters other than eoc are TW bits wide; the trickle fault needs at least one tick of TIMEOUT/8
   if (TOSC_CYC < 2 || PLUG_TICKS < 1 || SETTLE_TICKS < 1 || VERIFY_TICKS < 1 ||
       TIMEOUT_TICKS < 8 || TIMEOUT_TICKS >= (1 << TW) ||
       TOSC_CYC >= (1 << TW)) begin : g_bad_param
      $error("lcs_charge_seq: unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [10:0] sync1;
      logic [10:0] sync2;
      logic        en_prev;
      logic [TW-1:0] div;
      logic        tick;
      lcs_state_t  st;
      logic [TW-1:0] cnt;
      logic [TW-1:0] tmo;
      logic [TW-1:0] low;
      logic [2:0]  eoc;
      logic [TW-1:0] flash_cnt;
      logic        flash;
      logic        ctrl_hold;
      logic        ctrl_force_done;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic [31:0] dat;
      logic        ack;
      logic        red;
      logic        green_indicator_drive;
      logic        chg;
      lcs_phase_t  ph;
      logic        fold;
      logic        irq;
   } lcs_regs_t;

   lcs_regs_t r_reg;
   lcs_regs_t r_next;

   logic en_n;
   logic open_s;
   logic lt1v;
   logic ltvmin;
   logic at_tgt;
   logic lt_rchg;
   logic cur_low;
   logic amb_low;
   logic amb_hi_idle;
   logic amb_hi_chg;
   logic die_hot;
   logic temp_ok;
   logic charging;
   logic [3:0] ev;
   logic wb_hit;

   assign {en_n, open_s, lt1v, ltvmin, at_tgt, lt_rchg, cur_low, amb_low, amb_hi_idle,
           amb_hi_chg, die_hot} = r_reg.sync2;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      r_next = r_reg;
      ev = 4'h0;
      wb_hit = WB_CYC_I && WB_STB_I && !r_reg.ack;

      r_next.sync1 = {CHARGE_EN_N, BAT_OPEN, BAT_BELOW_1V, BAT_BELOW_VMIN, BAT_AT_TARGET,
                      BAT_BELOW_RECHG, CUR_BELOW_MIN, AMB_BELOW_LOW, AMB_ABOVE_IDLE_MAX,
                      AMB_ABOVE_CHG_MAX, DIE_HOT};
      r_next.sync2 = r_reg.sync1;
      r_next.en_prev = en_n;

      // Oscillator tick
      r_next.tick = 1'b0;
      if (r_reg.div == TW'(TOSC_CYC - 1)) begin
         r_next.div = '0;
         r_next.tick = 1'b1;
      end else begin
         r_next.div = r_reg.div + 1'b1;
      end

      if (r_reg.tick) begin
         if (r_reg.flash_cnt == TW'(`LCS_FLASH_TICKS - 1)) begin
            r_next.flash_cnt = '0;
            r_next.flash = !r_reg.flash;
         end else begin
            r_next.flash_cnt = r_reg.flash_cnt + 1'b1;
         end
      end

      charging = (r_reg.st == LCS_TRICKLE) || (r_reg.st == LCS_FAST) ||
                 (r_reg.st == LCS_SHORT_CHK) || (r_reg.st == LCS_VERIFY);
      temp_ok = !amb_low && !(charging ? amb_hi_chg : amb_hi_idle);

      if (r_reg.tick) begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end

      unique case (r_reg.st)
         LCS_PLUG_RED: begin
            if (r_reg.tick && r_reg.cnt == TW'(PLUG_TICKS - 1)) begin
               r_next.st = LCS_PLUG_GRN;
               r_next.cnt = '0;
            end
         end
         LCS_PLUG_GRN: begin
            if (r_reg.tick && r_reg.cnt == TW'(PLUG_TICKS - 1)) begin
               r_next.st = LCS_PLUG_YEL;
               r_next.cnt = '0;
            end
         end
         LCS_PLUG_YEL: begin
            if (r_reg.tick && r_reg.cnt == TW'(PLUG_TICKS - 1)) begin
               r_next.st = LCS_IDLE;
               r_next.cnt = '0;
            end
         end
         LCS_IDLE: begin
            r_next.cnt = '0;
            if (!en_n && temp_ok && !r_reg.ctrl_hold) begin
               r_next.st = LCS_SETTLE;
            end
         end
         LCS_SETTLE: begin
            if (r_reg.tick && r_reg.cnt == TW'(SETTLE_TICKS - 1)) begin
               r_next.st = LCS_VERIFY;
               r_next.cnt = '0;
            end
         end
         LCS_VERIFY: begin
            if (r_reg.tick && r_reg.cnt == TW'(VERIFY_TICKS - 1)) begin
               r_next.cnt = '0;
               if (open_s) begin
                  r_next.st = LCS_OPEN;
                  ev[1] = 1'b1;
               end else begin
                  r_next.st = LCS_SHORT_CHK;
               end
            end
         end
         LCS_SHORT_CHK: begin
            if (r_reg.tick && r_reg.cnt == TW'(`LCS_SHORT_TICKS - 1)) begin
               r_next.cnt = '0;
               r_next.low = '0;
               r_next.tmo = '0;
               if (lt1v) begin
                  r_next.st = LCS_FAULT;
                  ev[1] = 1'b1;
               end else begin
                  r_next.st = LCS_TRICKLE;
               end
            end
         end
         LCS_TRICKLE: begin
            if (r_reg.tick) begin
               r_next.tmo = r_reg.tmo + 1'b1;
               r_next.low = ltvmin ? r_reg.low + 1'b1 : '0;
               if (ltvmin && r_reg.low == TW'(TIMEOUT_TICKS / 8 - 1)) begin
                  r_next.st = LCS_FAULT;
                  ev[1] = 1'b1;
               end else if (!ltvmin && r_reg.cnt >= TW'(`LCS_TRK_MIN_TICKS - 1)) begin
                  r_next.st = LCS_FAST;
                  r_next.eoc = '0;
               end
            end
         end
         LCS_FAST: begin
            if (r_reg.tick) begin
               r_next.tmo = r_reg.tmo + 1'b1;
               r_next.eoc = (cur_low && at_tgt) ? r_reg.eoc + 1'b1 : 3'h0;
               if ((cur_low && at_tgt && r_reg.eoc == 3'(`LCS_EOC_TICKS - 1)) ||
                   r_reg.tmo == TW'(TIMEOUT_TICKS - 1) || r_reg.ctrl_force_done) begin
                  r_next.st = LCS_DONE;
                  ev[0] = 1'b1;
               end
            end
         end
         LCS_DONE: begin
            if (lt_rchg && temp_ok) begin
               r_next.st = LCS_TRICKLE;
               r_next.cnt = '0;
               r_next.tmo = '0;
               r_next.low = '0;
               ev[2] = 1'b1;
            end
         end
         LCS_FAULT, LCS_OPEN: begin
            r_next.cnt = '0;
         end
         default: begin
            r_next.st = LCS_IDLE;
         end
      endcase

      // Removal ends any charge activity; faults clear on enable toggling.
      // Enable is ignored while the power-up indication runs, so the
      // sequence always completes before the first charge can start.
      if (r_reg.st != LCS_PLUG_RED && r_reg.st != LCS_PLUG_GRN && r_reg.st != LCS_PLUG_YEL &&
          en_n && !r_reg.en_prev) begin
         r_next.st = LCS_IDLE;
         r_next.cnt = '0;
      end
      if (charging && !temp_ok) begin
         r_next.st = LCS_IDLE;
         r_next.cnt = '0;
         ev[3] = 1'b1;
      end

      // Outputs
      r_next.red = 1'b0;
      r_next.green_indicator_drive = 1'b0;
      r_next.chg = 1'b0;
      r_next.ph = LCS_PH_OFF;
      unique case (r_next.st)
         LCS_PLUG_RED: r_next.red = 1'b1;
         LCS_PLUG_GRN: r_next.green_indicator_drive = 1'b1;
         LCS_PLUG_YEL: begin
            r_next.red = 1'b1;
            r_next.green_indicator_drive = 1'b1;
         end
         LCS_VERIFY, LCS_SHORT_CHK: begin
            r_next.chg = 1'b1;
            r_next.ph = LCS_PH_TRK;
         end
         LCS_TRICKLE: begin
            r_next.red = 1'b1;
            r_next.chg = 1'b1;
            r_next.ph = LCS_PH_TRK;
         end
         LCS_FAST: begin
            r_next.red = 1'b1;
            r_next.chg = 1'b1;
            r_next.ph = at_tgt ? LCS_PH_CV : LCS_PH_CC;
         end
         LCS_DONE: r_next.green_indicator_drive = 1'b1;
         LCS_FAULT: begin
            r_next.red = r_reg.flash;
            r_next.green_indicator_drive = r_reg.flash;
         end
         default: ;
      endcase
      r_next.fold = die_hot && r_next.chg;

      // Wishbone slave
      // Ack rises on the taking edge, one cycle after the request, and never stands two
      // cycles, so a master holding stb is not served twice.
      r_next.ack = wb_hit;
      r_next.dat = 32'h0;
      if (wb_hit) begin
         unique case (WB_ADR_I)
            `LCS_ADR_CTRL:
               r_next.dat = {30'h0, r_reg.ctrl_force_done, r_reg.ctrl_hold};
            `LCS_ADR_STATUS:
               r_next.dat = {22'h0, r_reg.fold, r_reg.ph, r_reg.chg, r_reg.green_indicator_drive, r_reg.red,
                             r_reg.st};
            `LCS_ADR_IRQ_STAT: r_next.dat = {28'h0, r_reg.irq_stat};
            `LCS_ADR_IRQ_MASK: r_next.dat = {28'h0, r_reg.irq_mask};
            default: r_next.dat = 32'h0;
         endcase
         if (WB_WE_I && WB_SEL_I[0]) begin
            unique case (WB_ADR_I)
               `LCS_ADR_CTRL: begin
                  r_next.ctrl_hold = WB_DAT_I[0];
                  r_next.ctrl_force_done = WB_DAT_I[1];
               end
               `LCS_ADR_IRQ_STAT: r_next.irq_stat = r_reg.irq_stat & ~WB_DAT_I[3:0];
               `LCS_ADR_IRQ_MASK: r_next.irq_mask = WB_DAT_I[3:0];
               default: ;
            endcase
         end
      end
      // Events are merged after the clear so that a same-cycle event wins
      r_next.irq_stat = r_next.irq_stat | ev;
      r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         r_reg <= '0;
         r_reg.sync1 <= 11'h7FF;
         r_reg.sync2 <= 11'h7FF;
         r_reg.en_prev <= 1'b1;
         r_reg.st <= LCS_PLUG_RED;
         r_reg.red <= 1'b1;
         r_reg.ctrl_hold <= `LCS_CTRL_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign WB_DAT_O = r_reg.dat;
   assign WB_ACK_O = r_reg.ack;
   assign RED_DRIVE_OE = r_reg.red;
   assign GREEN_INDICATOR_DRIVE_OE = r_reg.green_indicator_drive;
   assign CHARGE_ON = r_reg.chg;
   assign CHARGE_PHASE = r_reg.ph;
   assign FOLDBACK = r_reg.fold;
   assign IRQ = r_reg.irq;
endmodule : lcs_charge_seq

// file: rtl/lcs_map.svh
// Constants of the charge sequencer: timing counts, register map
//
// Contract
// - After power-up show red, then green, then yellow, then all indicators off.
// - Each power-up indicator step lasts 500 ms.
// - After indication stay idle until the active-low enable goes low.
// - Enable low starts a 500 ms settling delay before connection verification.
// - Battery not connected: no charging, both indicators off.
// - Verify with trickle for 70 ms; open battery latches off until enable toggles.
// - Connected battery gets a short check; if passed, trickle with red indicator.
// - Short check forces trickle 384 ticks; below 1 V means fault, flash yellow.
// - Every charge cycle starts with trickle until above fast-charge threshold.
// - Cell at or below 2.8 V for 1/8 of time limit: fault, flash yellow.
// - Above threshold: constant current until target, then constant voltage at 4.2 V.
// - Current at end-of-charge level signals completion, red changes to green.
// - Expiry of the charge time limit also signals completion.
// - After completion, recharge at the recharge threshold until full again, then stop.
// - Completion and recharge repeat until the enable goes high.
// - No charging while ambient temperature is out of range.
// - Higher upper ambient limit applies while a charge is in progress.
// - Charge current is reduced whenever the die temperature reaches 100 C.
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH

`define LCS_CLK_MHZ        250
`define LCS_TOSC_NS        3000000
`define LCS_TOSC_CYC       (`LCS_TOSC_NS * `LCS_CLK_MHZ / 1000)
`define LCS_PLUG_MS        500
`define LCS_SETTLE_MS      500
`define LCS_VERIFY_MS      70
`define LCS_SHORT_TICKS    384
`define LCS_TRK_MIN_TICKS  15
`define LCS_EOC_TICKS      3
`define LCS_TIMEOUT_TICKS  20000
`define LCS_FLASH_TICKS    100
`define LCS_TICK_W         24

`define LCS_ADR_CTRL       8'h00
`define LCS_ADR_STATUS     8'h04
`define LCS_ADR_IRQ_STAT   8'h08
`define LCS_ADR_IRQ_MASK   8'h0C
`define LCS_CTRL_RESET     1'h0
`define LCS_IRQ_W          4

`endif

// file: rtl/lcs_pkg.sv
// Types of the charge sequencer
package lcs_pkg;
   typedef enum logic [3:0] {
      LCS_PLUG_RED   = 4'h0,
      LCS_PLUG_GRN   = 4'h1,
      LCS_PLUG_YEL   = 4'h3,
      LCS_IDLE       = 4'h2,
      LCS_SETTLE     = 4'h6,
      LCS_VERIFY     = 4'h7,
      LCS_SHORT_CHK  = 4'h5,
      LCS_TRICKLE    = 4'h4,
      LCS_FAST       = 4'hC,
      LCS_DONE       = 4'hD,
      LCS_FAULT      = 4'hF,
      LCS_OPEN       = 4'hE
   } lcs_state_t;

   typedef enum logic [1:0] {
      LCS_PH_OFF   = 2'h0,
      LCS_PH_TRK   = 2'h1,
      LCS_PH_CC    = 2'h2,
      LCS_PH_CV    = 2'h3
   } lcs_phase_t;
endpackage : lcs_pkg

// file: testbench/lcs_pack_model.sv
// Battery pack and current-limited adapter seen through the comparators
`timescale 1ns/1ps
module lcs_pack_model (
   input  wire logic clk,
   input  wire logic on,
   input  wire logic present,
   input  wire logic shorted,
   input  wire logic dead,
   input  wire logic drain,
   input  wire logic stuck,
   output logic      bat_open,
   output logic      below_1v,
   output logic      below_vmin,
   output logic      at_target,
   output logic      below_rechg,
   output logic      cur_low
);
   logic [7:0] v_reg;
   initial v_reg = 8'h00;
   // Cell voltage climbs while the charger feeds a present cell
   always_ff @(posedge clk) begin
      if (drain)
         v_reg <= 8'h64;
      else if (on && present && v_reg < 8'hC8)
         v_reg <= v_reg + 8'h01;
   end
   // Sense pin floats up to the supply when no cell is there
   assign bat_open    = !present;
   assign below_1v    = shorted || v_reg < 8'h0A;
   assign below_vmin  = dead || v_reg < 8'h28;
   assign at_target   = v_reg >= 8'hC8;
   assign below_rechg = v_reg < 8'h96;
   assign cur_low     = at_target && !stuck;
endmodule : lcs_pack_model

// file: testbench/lcs_charge_seq_monitor.sv
// Port checker of the charge sequencer
`timescale 1ns/1ps
module lcs_charge_seq_monitor (
   input wire logic                SYS_CLK,
   input wire logic                SRST,
   input wire logic                CHARGE_EN_N,
   input wire logic                AMB_ABOVE_CHG_MAX,
   input wire logic                DIE_HOT,
   input wire logic                WB_CYC_I,
   input wire logic                WB_STB_I,
   input wire logic                WB_ACK_O,
   input wire logic                RED_DRIVE_OE,
   input wire logic                GREEN_INDICATOR_DRIVE_OE,
   input wire logic                CHARGE_ON,
   input wire lcs_pkg::lcs_phase_t CHARGE_PHASE,
   input wire logic                FOLDBACK
);
   import lcs_pkg::*;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   AST_ACK: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("bus request not answered");
   AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   AST_RST: assert property ($fell(SRST) |-> RED_DRIVE_OE && !CHARGE_ON)
      else $error("outputs wrong after reset");
   AST_EN_OFF: assert property (CHARGE_EN_N [*5] |=> !CHARGE_ON)
      else $error("charging while disabled");
   AST_AMB: assert property (AMB_ABOVE_CHG_MAX [*5] |=> !CHARGE_ON)
      else $error("charging while too hot");
   AST_FOLD: assert property ((DIE_HOT && CHARGE_ON) [*5] |-> FOLDBACK)
      else $error("no current foldback");
   AST_TRK: assert property ($rose(CHARGE_ON) |-> CHARGE_PHASE == LCS_PH_TRK)
      else $error("charge did not start in trickle");
   AST_PH: assert property (CHARGE_ON == (CHARGE_PHASE != LCS_PH_OFF))
      else $error("phase and charge enable disagree");
   AST_GRN: assert property (GREEN_INDICATOR_DRIVE_OE && !RED_DRIVE_OE |-> !CHARGE_ON)
      else $error("charging under complete indication");
   cover property ($rose(FOLDBACK));
   cover property (CHARGE_PHASE == LCS_PH_CV);
   cover property ($rose(GREEN_INDICATOR_DRIVE_OE) && !RED_DRIVE_OE);
endmodule : lcs_charge_seq_monitor
bind lcs_charge_seq lcs_charge_seq_monitor u_mon (.*);

// file: testbench/li_ion_charge_sequencer_bench.sv
// Self-checking bench of the charge sequencer
`timescale 1ns/1ps
`define CHK(n,e,a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("Error %s expected %0h seen %0h", n, e, a); end end
`define WT(c) begin k = 0; while (!(c) && k < 9000) begin @(posedge clk); k++; end \
   if (k >= 9000) begin n_errors++; finish_test(); end end
module li_ion_charge_sequencer_bench;
   import lcs_pkg::*;
   logic        clk, srst, en_n, amb_lo, amb_idle, amb_chg, hot, we, cyc, stb, ack;
   logic        red, green_indicator_drive, on, fold, irq, present, shorted, dead, drain, stuck;
   logic        b_open, b_1v, b_vmin, b_tgt, b_rch, c_low;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   lcs_phase_t  ph;
   int          n_errors = 0;
   int          total_checks = 0;
   int          k;
   lcs_charge_seq #(.TOSC_CYC(4), .PLUG_TICKS(4), .SETTLE_TICKS(2), .VERIFY_TICKS(2),
      .TIMEOUT_TICKS(64)) dut (.SYS_CLK(clk), .SRST(srst), .CHARGE_EN_N(en_n),
      .BAT_OPEN(b_open), .BAT_BELOW_1V(b_1v), .BAT_BELOW_VMIN(b_vmin), .BAT_AT_TARGET(b_tgt),
      .BAT_BELOW_RECHG(b_rch), .CUR_BELOW_MIN(c_low), .AMB_BELOW_LOW(amb_lo),
      .AMB_ABOVE_IDLE_MAX(amb_idle), .AMB_ABOVE_CHG_MAX(amb_chg), .DIE_HOT(hot),
      .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack), .RED_DRIVE_OE(red),
      .GREEN_INDICATOR_DRIVE_OE(green_indicator_drive), .CHARGE_ON(on), .CHARGE_PHASE(ph),
      .FOLDBACK(fold), .IRQ(irq));
   lcs_pack_model pack (.clk(clk), .on(on), .present(present), .shorted(shorted),
      .dead(dead), .drain(drain), .stuck(stuck), .bat_open(b_open), .below_1v(b_1v),
      .below_vmin(b_vmin), .at_target(b_tgt), .below_rechg(b_rch), .cur_low(c_low));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         n_errors++;
         finish_test();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic pulse_drain;
      drain <= 1'b1;
      @(posedge clk);
      drain <= 1'b0;
   endtask : pulse_drain
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_plug;
      `CHK("red", 1'b1, red)
      `WT(green_indicator_drive && !red)
      `WT(green_indicator_drive && red)
      `CHK("green step", 16, k)
      `WT(!green_indicator_drive && !red)
      `CHK("yellow step", 16, k)
      wb(1'b0, 8'h04, 32'h0);
      `CHK("idle", LCS_IDLE, q[3:0])
      repeat (30) @(posedge clk);
      `CHK("no charge", 1'b0, on)
   endtask : t_plug
   task automatic t_regs;
      wb(1'b0, 8'h00, 32'h0);
      `CHK("ctrl", 32'h0, q)
      wb(1'b1, 8'h0C, 32'hF);
      wb(1'b0, 8'h0C, 32'h0);
      `CHK("mask", 32'hF, q)
      wb(1'b1, 8'h10, 32'hFFFFFFFF);
      wb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 32'h0, q)
   endtask : t_regs
   task automatic t_charge;
      hot <= 1'b1;
      en_n <= 1'b0;
      `WT(on)
      `CHK("settle", 1'b1, k >= 8 && k <= 16)
      `CHK("verify", LCS_PH_TRK, ph)
      `WT(red && !green_indicator_drive)
      `CHK("trickle", LCS_PH_TRK, ph)
      `WT(ph == LCS_PH_CV)
      `CHK("fold", 1'b1, fold)
      hot <= 1'b0;
      `WT(green_indicator_drive && !red)
      `CHK("done off", 1'b0, on)
      `CHK("irq", 1'b1, irq)
      wb(1'b0, 8'h08, 32'h0);
      `CHK("done flag", 1'b1, q[0])
      wb(1'b1, 8'h0C, 32'h0);
      repeat (2) @(posedge clk);
      `CHK("masked", 1'b0, irq)
      wb(1'b1, 8'h0C, 32'hF);
      wb(1'b1, 8'h08, 32'hF);
      repeat (2) @(posedge clk);
      `CHK("cleared", 1'b0, irq)
   endtask : t_charge
   task automatic t_rechg;
      pulse_drain();
      `WT(on)
      `CHK("rechg red", 2'b10, {red, green_indicator_drive})
      `WT(green_indicator_drive && !red)
      `CHK("rechg end", 1'b0, on)
   endtask : t_rechg
   task automatic t_limit;
      stuck <= 1'b1;
      pulse_drain();
      `WT(on)
      `WT(green_indicator_drive && !red)
      `CHK("time limit", 1'b1, k >= 252 && k <= 257)
      stuck <= 1'b0;
   endtask : t_limit
   task automatic t_temp;
      pulse_drain();
      `WT(on)
      amb_idle <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("raised limit", 1'b1, on)
      amb_chg <= 1'b1;
      `WT(!on)
      wb(1'b0, 8'h08, 32'h0);
      `CHK("temp flag", 1'b1, q[3])
      amb_chg <= 1'b0;
      amb_idle <= 1'b0;
      en_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask : t_temp
   task automatic t_open;
      present <= 1'b0;
      amb_lo <= 1'b1;
      en_n <= 1'b0;
      repeat (60) @(posedge clk);
      `CHK("cold", 1'b0, on)
      amb_lo <= 1'b0;
      `WT(on)
      `WT(!on)
      repeat (20) @(posedge clk);
      `CHK("open leds", 2'b00, {red, green_indicator_drive})
      present <= 1'b1;
      repeat (40) @(posedge clk);
      `CHK("open stays", 1'b0, on)
      en_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask : t_open
   task automatic t_fault(input logic s);
      shorted <= s;
      dead <= !s;
      en_n <= 1'b0;
      `WT(red && green_indicator_drive)
      `CHK("fault off", 1'b0, on)
      shorted <= 1'b0;
      dead <= 1'b0;
      en_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask : t_fault
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {en_n, srst, present, sel} = 7'h7F;
      {amb_lo, amb_idle, amb_chg, hot, cyc, stb, we, shorted, dead, drain, stuck} = 11'h0;
      adr = 8'h00;
      wdat = 32'h0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_plug();
      t_regs();
      t_charge();
      t_rechg();
      t_limit();
      t_temp();
      t_open();
      t_fault(1'b1);
      t_fault(1'b0);
      finish_test();
   end
endmodule : li_ion_charge_sequencer_bench
